// ### hw/bitrot_pkg.sv
// constants, opcodes and carrier types for the bit rotate and flag unit
package bitrot_pkg;

  // register byte addresses on the bus
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_DATA  = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_IO0   = 8'h10;
  localparam logic [7:0] ADDR_STEP  = 8'h04;
  localparam int         IO_COUNT   = 4;

  // processor_flags bit positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // reset values
  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] IO_RST    = 8'h00;

  // operations, codes 0 upward in this order
  typedef enum logic [4:0] {
    OP_NONE,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_ARITH_SHIFT_RIGHT,
    OP_NIBBLE_SWAP,
    OP_IO_BIT_FORCE_ONE,
    OP_IO_BIT_FORCE_ZERO,
    OP_REG_BIT_TO_COPY_FLAG,
    OP_COPY_FLAG_TO_REG_BIT,
    OP_FLAG_INDEX_FORCE_ONE,
    OP_FLAG_INDEX_FORCE_ZERO,
    OP_SIGNED_FLAG_FORCE_ONE,
    OP_SIGNED_FLAG_FORCE_ZERO,
    OP_OVERFLOW_FLAG_FORCE_ONE,
    OP_OVERFLOW_FLAG_FORCE_ZERO,
    OP_HALF_CARRY_FORCE_ONE,
    OP_HALF_CARRY_FORCE_ZERO
  } op_t;

  // control word: io_sel [9:8], bit_idx [7:5], op [4:0]
  typedef struct packed {
    logic [1:0] io_sel;
    logic [2:0] bit_idx;
    op_t        op;
  } ctrl_t;

  // result of a shift class operation
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] flags;
  } alu_out_t;

endpackage

// ### hw/bit_field_unit.sv
// single bit replace and extract on one byte
`timescale 1ns/1ps
module bit_field_unit
  import bitrot_pkg::*;
(
  // byte and selected bit
  input  wire logic [7:0] byte_i,
  input  wire logic [2:0] idx_i,
  input  wire logic       val_i,
  // byte with bit replaced, and old bit
  output logic      [7:0] byte_o,
  output logic            bit_o
);

  // one mux per bit position
  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign byte_o[i] = (idx_i == 3'(i)) ? val_i : byte_i[i];
  end

  // extracted bit, old value
  assign bit_o = byte_i[idx_i];

endmodule // bit_field_unit

// ### hw/shift_unit.sv
// rotate, arithmetic shift and nibble swap with flag update
`timescale 1ns/1ps
module shift_unit
  import bitrot_pkg::*;
(
  // operand and current flags
  input  wire op_t        op_i,
  input  wire logic [7:0] data_i,
  input  wire logic [7:0] flags_i,
  // result
  output alu_out_t        out_o
);

  logic [7:0] res;
  logic       cout;
  logic       upd;

  // result and carry out, per operation
  always_comb begin
    res  = data_i;
    cout = flags_i[FLAG_C];
    upd  = 1'b0;
    unique case (op_i)
      OP_ROTATE_LEFT_CARRY: begin
        res  = {data_i[6:0], flags_i[FLAG_C]};
        cout = data_i[7];
        upd  = 1'b1;
      end
      OP_ROTATE_RIGHT_CARRY: begin
        res  = {flags_i[FLAG_C], data_i[7:1]};
        cout = data_i[0];
        upd  = 1'b1;
      end
      OP_ARITH_SHIFT_RIGHT: begin
        res  = {data_i[7], data_i[7:1]}; // sign kept
        cout = data_i[0];
        upd  = 1'b1;
      end
      OP_NIBBLE_SWAP: res = {data_i[3:0], data_i[7:4]};
      default: ;
    endcase
  end

  // flags: swap touches none, the signed flag is left alone
  always_comb begin
    out_o.data  = res;
    out_o.flags = flags_i;
    if (upd) begin
      out_o.flags[FLAG_C] = cout;
      out_o.flags[FLAG_Z] = (res == 8'h00);
      out_o.flags[FLAG_N] = res[7];
      out_o.flags[FLAG_V] = res[7] ^ cout;
    end
    // half carry only on left rotate, from old bit 3
    if (op_i == OP_ROTATE_LEFT_CARRY) begin
      out_o.flags[FLAG_H] = data_i[3];
    end
  end

endmodule // shift_unit

// ### hw/bit_rotate_flag_unit.sv
// bit level execution unit: shifts, bit moves and flag forcing behind wishbone
//
// Contract
// - rotate left through carry moves bits up, old carry to bit 0, old bit 7 to carry, updates Z C N V H, one cycle.
// - rotate right through carry moves bits down, old carry to bit 7, old bit 0 to carry, updates Z C N V, one cycle.
// - io bit force one sets the chosen bit of the chosen io register, nothing else, one cycle.
// - io bit force zero clears the chosen bit of the chosen io register, nothing else, one cycle.
// - register bit to copy flag copies the chosen data bit into T and touches no other flag, one cycle.
// - copy flag to register bit writes T into the chosen data bit, no flag changes, one cycle.
// - dedicated operations force the signed flag to one or zero alone, one cycle.
// - dedicated operations force the overflow flag to one or zero alone, one cycle.
// - dedicated operations force the half carry flag to one or zero alone, one cycle.
// - every other flag has one-cycle set and clear, and indexed set or clear alters only that flag.
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module bit_rotate_flag_unit
  import bitrot_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // flag state toward the core
  output logic      [7:0]  flags_o,
  output logic             irq_enable_o
);

  logic       ack_q;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic [7:0] data_q;
  logic [7:0] flags_q;
  logic [7:0] io_q [IO_COUNT];
  ctrl_t      last_q;
  ctrl_t      ctrl;
  logic       req;
  logic       wr;
  logic       exec;
  logic       shift_op;
  logic       io_op;
  logic       flag_hit;
  logic       flag_val;
  logic [2:0] flag_idx;
  logic [7:0] io_new;
  logic [7:0] data_ins;
  logic       data_bit;
  logic [7:0] flags_new;
  alu_out_t   sh;

  // bus request and the decoded control word
  assign req  = wb_cyc_i & wb_stb_i;
  assign wr   = ack_q & req & wb_we_i;
  assign ctrl = ctrl_t'(wb_dat_i[9:0]);
  // an operation fires on the acked write of the control word
  assign exec = wr & (wb_adr_i == ADDR_CTRL) & wb_sel_i[0];

  // one wait cycle, ack drops the cycle after it was given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // read mux, unmapped words read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    if (wb_adr_i == ADDR_CTRL) begin
      rd_d = {22'h0, last_q};
    end else if (wb_adr_i == ADDR_DATA) begin
      rd_d = {24'h00_0000, data_q};
    end else if (wb_adr_i == ADDR_FLAGS) begin
      rd_d = {24'h00_0000, flags_q};
    end else if (wb_adr_i[7:4] == ADDR_IO0[7:4] && wb_adr_i[1:0] == 2'h0) begin
      rd_d = {24'h00_0000, io_q[wb_adr_i[3:2]]};
    end
  end

  // read data captured with the ack so it comes from a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_q <= 32'h0000_0000;
    end else if (req & ~ack_q) begin
      rd_q <= rd_d;
    end
  end

  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = rd_q;
  assign flags_o      = flags_q;
  assign irq_enable_o = flags_q[FLAG_I];

  // operation classes
  assign shift_op = (ctrl.op == OP_ROTATE_LEFT_CARRY) | (ctrl.op == OP_ROTATE_RIGHT_CARRY) |
                    (ctrl.op == OP_ARITH_SHIFT_RIGHT) | (ctrl.op == OP_NIBBLE_SWAP);
  assign io_op    = (ctrl.op == OP_IO_BIT_FORCE_ONE) | (ctrl.op == OP_IO_BIT_FORCE_ZERO);

  // flag forcing: indexed forms take bit_idx, dedicated ones a fixed flag
  always_comb begin
    flag_hit = 1'b0;
    flag_val = 1'b0;
    flag_idx = ctrl.bit_idx;
    unique case (ctrl.op)
      OP_FLAG_INDEX_FORCE_ONE: begin
        flag_hit = 1'b1;
        flag_val = 1'b1;
      end
      OP_FLAG_INDEX_FORCE_ZERO: flag_hit = 1'b1;
      OP_SIGNED_FLAG_FORCE_ONE: begin
        flag_hit = 1'b1;
        flag_val = 1'b1;
        flag_idx = FLAG_S;
      end
      OP_SIGNED_FLAG_FORCE_ZERO: begin
        flag_hit = 1'b1;
        flag_idx = FLAG_S;
      end
      OP_OVERFLOW_FLAG_FORCE_ONE: begin
        flag_hit = 1'b1;
        flag_val = 1'b1;
        flag_idx = FLAG_V;
      end
      OP_OVERFLOW_FLAG_FORCE_ZERO: begin
        flag_hit = 1'b1;
        flag_idx = FLAG_V;
      end
      OP_HALF_CARRY_FORCE_ONE: begin
        flag_hit = 1'b1;
        flag_val = 1'b1;
        flag_idx = FLAG_H;
      end
      OP_HALF_CARRY_FORCE_ZERO: begin
        flag_hit = 1'b1;
        flag_idx = FLAG_H;
      end
      default: ; // other codes leave flags to their own paths
    endcase
  end

  // shifts, rotates and swap
  shift_unit u_shift (
    .op_i    (ctrl.op),
    .data_i  (data_q),
    .flags_i (flags_q),
    .out_o   (sh)
  );

  // io bit forcing on the selected io register
  bit_field_unit u_io_bit (
    .byte_i (io_q[ctrl.io_sel]),
    .idx_i  (ctrl.bit_idx),
    .val_i  (ctrl.op == OP_IO_BIT_FORCE_ONE),
    .byte_o (io_new),
    .bit_o  ()
  );

  // data bit insert of T, and extract for the copy flag
  bit_field_unit u_data_bit (
    .byte_i (data_q),
    .idx_i  (ctrl.bit_idx),
    .val_i  (flags_q[FLAG_T]),
    .byte_o (data_ins),
    .bit_o  (data_bit)
  );

  // single flag replace for all forcing forms
  bit_field_unit u_flag_bit (
    .byte_i (flags_q),
    .idx_i  (flag_idx),
    .val_i  (flag_val),
    .byte_o (flags_new),
    .bit_o  ()
  );

  // data register: operations win over a plain write, they cannot coincide
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_q <= DATA_RST;
    end else if (exec & shift_op) begin
      data_q <= sh.data;
    end else if (exec & (ctrl.op == OP_COPY_FLAG_TO_REG_BIT)) begin
      data_q <= data_ins;
    end else if (wr & (wb_adr_i == ADDR_DATA) & wb_sel_i[0]) begin
      data_q <= wb_dat_i[7:0];
    end
  end

  // processor flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= FLAGS_RST;
    end else if (exec & shift_op) begin
      flags_q <= sh.flags;
    end else if (exec & (ctrl.op == OP_REG_BIT_TO_COPY_FLAG)) begin
      flags_q[FLAG_T] <= data_bit;
    end else if (exec & flag_hit) begin
      flags_q <= flags_new;
    end else if (wr & (wb_adr_i == ADDR_FLAGS) & wb_sel_i[0]) begin
      flags_q <= wb_dat_i[7:0];
    end
  end

  // io registers, one per entry
  for (genvar i = 0; i < IO_COUNT; i++) begin : g_io
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        io_q[i] <= IO_RST;
      end else if (exec & io_op & (ctrl.io_sel == 2'(i))) begin
        io_q[i] <= io_new;
      end else if (wr & (wb_adr_i == ADDR_IO0 + ADDR_STEP * 8'(i)) & wb_sel_i[0]) begin
        io_q[i] <= wb_dat_i[7:0];
      end
    end
  end

  // last executed control word, readable for debug
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_q <= ctrl_t'(10'h000);
    end else if (exec) begin
      last_q <= ctrl;
    end
  end

  // helper copies of the firing operation, read only by the checks
  ctrl_t ctrl_d;
  logic  exec_d;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_d <= ctrl_t'(10'h000);
      exec_d <= 1'b0;
    end else begin
      ctrl_d <= ctrl;
      exec_d <= exec;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_rol_result: assert property (
    exec && ctrl.op == OP_ROTATE_LEFT_CARRY |=>
      data_q == {$past(data_q[6:0]), $past(flags_q[FLAG_C])} && flags_q[FLAG_C] == $past(data_q[7]) &&
      flags_q[FLAG_H] == $past(data_q[3]) && flags_q[FLAG_Z] == (data_q == 8'h00))
    else $error("rotate left result or flags wrong");

  a_ror_result: assert property (
    exec && ctrl.op == OP_ROTATE_RIGHT_CARRY |=>
      data_q == {$past(flags_q[FLAG_C]), $past(data_q[7:1])} && flags_q[FLAG_C] == $past(data_q[0]) &&
      flags_q[FLAG_V] == (data_q[7] ^ flags_q[FLAG_C]) && flags_q[FLAG_H] == $past(flags_q[FLAG_H]))
    else $error("rotate right result or flags wrong");

  a_io_force_one: assert property (
    exec && ctrl.op == OP_IO_BIT_FORCE_ONE |=>
      io_q[ctrl_d.io_sel] == ($past(io_q[ctrl.io_sel]) | (8'h01 << ctrl_d.bit_idx)) && $stable(flags_q))
    else $error("io bit force one wrong");

  a_io_force_zero: assert property (
    exec && ctrl.op == OP_IO_BIT_FORCE_ZERO |=>
      io_q[ctrl_d.io_sel] == ($past(io_q[ctrl.io_sel]) & ~(8'h01 << ctrl_d.bit_idx)) && $stable(flags_q))
    else $error("io bit force zero wrong");

  a_copy_flag_store: assert property (
    exec_d && ctrl_d.op == OP_REG_BIT_TO_COPY_FLAG |->
      flags_q[FLAG_T] == $past(data_q[ctrl.bit_idx]) &&
      (flags_q & 8'hBF) == ($past(flags_q) & 8'hBF) && $stable(data_q))
    else $error("copy flag store wrong");

  a_copy_flag_load: assert property (
    exec && ctrl.op == OP_COPY_FLAG_TO_REG_BIT ##1 1'b1 |->
      data_q[ctrl_d.bit_idx] == flags_q[FLAG_T] && $stable(flags_q))
    else $error("copy flag load wrong");

  a_signed_force: assert property (
    exec && (ctrl.op == OP_SIGNED_FLAG_FORCE_ONE || ctrl.op == OP_SIGNED_FLAG_FORCE_ZERO) |=>
      flags_q[FLAG_S] == (ctrl_d.op == OP_SIGNED_FLAG_FORCE_ONE) &&
      (flags_q & 8'hEF) == ($past(flags_q) & 8'hEF))
    else $error("signed flag force wrong");

  a_overflow_force: assert property (
    exec && (ctrl.op == OP_OVERFLOW_FLAG_FORCE_ONE || ctrl.op == OP_OVERFLOW_FLAG_FORCE_ZERO) |=>
      flags_q == (($past(flags_q) & 8'hF7) | {4'h0, ctrl_d.op == OP_OVERFLOW_FLAG_FORCE_ONE, 3'h0}))
    else $error("overflow flag force wrong");

  a_half_force: assert property (
    exec && ctrl.op == OP_HALF_CARRY_FORCE_ONE |=> flags_q == ($past(flags_q) | 8'h20))
    else $error("half carry force wrong");

  a_index_force: assert property (
    exec && ctrl.op == OP_FLAG_INDEX_FORCE_ZERO |=>
      flags_q == ($past(flags_q) & ~(8'h01 << ctrl_d.bit_idx)) && $stable(data_q))
    else $error("indexed flag clear wrong");

  a_asr_result: assert property (
    exec && ctrl.op == OP_ARITH_SHIFT_RIGHT |=>
      data_q == {$past(data_q[7]), $past(data_q[7:1])} && flags_q[FLAG_C] == $past(data_q[0]) &&
      flags_q[FLAG_N] == data_q[7])
    else $error("arithmetic shift right wrong");

  a_swap_result: assert property (
    exec && ctrl.op == OP_NIBBLE_SWAP |=>
      data_q == {$past(data_q[3:0]), $past(data_q[7:4])} && $stable(flags_q))
    else $error("nibble swap wrong");

endmodule // bit_rotate_flag_unit

// ### bench/bit_rotate_flag_unit_tb.sv
// self-checking bench for the bit rotate and flag unit over wishbone
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module bit_rotate_flag_unit_tb;
  import bitrot_pkg::*;

  localparam int TIMEOUT = 30000;

  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [7:0]  flags_o;
  logic        irq_enable_o;
  int          err_count;
  int          compares;
  int          cycles;
  logic [31:0] exp_q[$];
  string       name_q[$];
  logic [7:0]  data_m;
  logic [7:0]  flags_m;
  logic [7:0]  io_m[IO_COUNT];

  bit_rotate_flag_unit bit_rotate_flag_unit_inst (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .wb_cyc_i     (wb_cyc_i),
    .wb_stb_i     (wb_stb_i),
    .wb_we_i      (wb_we_i),
    .wb_adr_i     (wb_adr_i),
    .wb_sel_i     (wb_sel_i),
    .wb_dat_i     (wb_dat_i),
    .wb_dat_o     (wb_dat_o),
    .wb_ack_o     (wb_ack_o),
    .flags_o      (flags_o),
    .irq_enable_o (irq_enable_o)
  );

  // 40 MHz core clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard, far above the expected run length
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      err_count++;
      print_verdict();
    end
  end

  // classic cycle: hold everything until ack is sampled, then release for a cycle
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    // only the bench timeout ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] v);
    wb_xfer(1'b1, adr, 4'hF, {24'h000000, v});
  endtask

  // note the expected word, the monitor compares it at the ack
  task automatic rd(input logic [7:0] adr, input logic [31:0] e, input string nm);
    exp_q.push_back(e);
    name_q.push_back(nm);
    wb_xfer(1'b0, adr, 4'hF, 32'h00000000);
  endtask

  task automatic rd_all();
    rd(ADDR_DATA, {24'h0, data_m}, "data");
    rd(ADDR_FLAGS, {24'h0, flags_m}, "flags");
    for (int k = 0; k < IO_COUNT; k++) begin
      rd(ADDR_IO0 + ADDR_STEP * 8'(k), {24'h0, io_m[k]}, "io");
    end
  endtask

  // read monitor: oldest note against what the bus returns
  always @(posedge clk_i) begin
    logic [31:0] e;
    string       nm;
    if (rst_i === 1'b0 && wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) begin
        `CHK("unexpected_ack", 32'h0, 32'h1);
      end else begin
        e  = exp_q.pop_front();
        nm = name_q.pop_front();
        `CHK(nm, e, wb_dat_o);
        if (nm == "flags") begin
          `CHK("flags_o", e[7:0], flags_o);
          `CHK("irq_enable_o", e[7], irq_enable_o);
        end
      end
    end
  end

  // reference behaviour of one executed control word
  task automatic model(input logic [4:0] code, input logic [2:0] idx, input logic [1:0] sel);
    logic [7:0] d;
    logic [7:0] f;
    logic [7:0] r;
    d = data_m;
    f = flags_m;
    r = d;
    case (code)
      OP_ROTATE_LEFT_CARRY: begin
        r = {d[6:0], f[FLAG_C]};
        f[FLAG_C] = d[7];
        f[FLAG_H] = d[3];
      end
      OP_ROTATE_RIGHT_CARRY: begin
        r = {f[FLAG_C], d[7:1]};
        f[FLAG_C] = d[0];
      end
      OP_ARITH_SHIFT_RIGHT: begin
        r = {d[7], d[7:1]};
        f[FLAG_C] = d[0];
      end
      OP_NIBBLE_SWAP: r = {d[3:0], d[7:4]};
      OP_IO_BIT_FORCE_ONE: io_m[sel][idx] = 1'b1;
      OP_IO_BIT_FORCE_ZERO: io_m[sel][idx] = 1'b0;
      OP_REG_BIT_TO_COPY_FLAG: f[FLAG_T] = d[idx];
      OP_COPY_FLAG_TO_REG_BIT: r[idx] = f[FLAG_T];
      OP_FLAG_INDEX_FORCE_ONE: f[idx] = 1'b1;
      OP_FLAG_INDEX_FORCE_ZERO: f[idx] = 1'b0;
      OP_SIGNED_FLAG_FORCE_ONE: f[FLAG_S] = 1'b1;
      OP_SIGNED_FLAG_FORCE_ZERO: f[FLAG_S] = 1'b0;
      OP_OVERFLOW_FLAG_FORCE_ONE: f[FLAG_V] = 1'b1;
      OP_OVERFLOW_FLAG_FORCE_ZERO: f[FLAG_V] = 1'b0;
      OP_HALF_CARRY_FORCE_ONE: f[FLAG_H] = 1'b1;
      OP_HALF_CARRY_FORCE_ZERO: f[FLAG_H] = 1'b0;
      default: ;
    endcase
    if (code >= 5'h01 && code <= 5'h03) begin
      f[FLAG_N] = r[7];
      f[FLAG_Z] = (r == 8'h00);
      f[FLAG_V] = r[7] ^ f[FLAG_C];
    end
    data_m  = r;
    flags_m = f;
  endtask

  // main sequence
  initial begin
    logic [31:0] rv;
    logic [2:0]  idx;
    logic [1:0]  sel;
    ctrl_t       c;
    err_count = 0;
    compares  = 0;
    cycles    = 0;
    rst_i     = 1'b1;
    wb_cyc_i  = 1'b0;
    wb_stb_i  = 1'b0;
    wb_we_i   = 1'b0;
    wb_adr_i  = 8'h00;
    wb_sel_i  = 4'h0;
    wb_dat_i  = 32'h00000000;
    data_m    = DATA_RST;
    flags_m   = FLAGS_RST;
    for (int k = 0; k < IO_COUNT; k++) io_m[k] = IO_RST;
    void'($urandom(60456));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_all();
    rd(ADDR_CTRL, 32'h0, "ctrl");
    // every op code with random operands, data zero in the eighth round, bit index walks through all eight
    for (int rnd = 0; rnd < 8; rnd++) begin
      for (int code = 0; code < 32; code++) begin
        rv  = $urandom;
        idx = 3'(rnd);
        sel = rv[28:27];
        data_m  = (rnd == 7) ? 8'h00 : rv[7:0];
        flags_m = rv[15:8];
        io_m[sel] = rv[23:16];
        wr(ADDR_DATA, data_m);
        wr(ADDR_FLAGS, flags_m);
        wr(ADDR_IO0 + ADDR_STEP * 8'(sel), io_m[sel]);
        c.io_sel  = sel;
        c.bit_idx = idx;
        c.op      = op_t'(code);
        // one execute per op: a second write of the control word would run it twice
        wb_xfer(1'b1, ADDR_CTRL, 4'hF, {22'h0, c});
        model(5'(code), idx, sel);
        rd_all();
        rd(ADDR_CTRL, {22'h0, c}, "ctrl");
      end
    end
    // lane 0 disabled and unmapped writes leave state alone, unmapped reads zero
    wb_xfer(1'b1, ADDR_DATA, 4'hE, ~{24'h0, data_m});
    wb_xfer(1'b1, 8'h40, 4'hF, 32'hFFFFFFFF);
    rd(8'h40, 32'h0, "unmapped");
    rd_all();
    // reset in mid run returns everything to its reset value
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    data_m  = DATA_RST;
    flags_m = FLAGS_RST;
    for (int k = 0; k < IO_COUNT; k++) io_m[k] = IO_RST;
    rd_all();
    rd(ADDR_CTRL, 32'h0, "ctrl");
    repeat (2) @(posedge clk_i);
    // every noted read must have been answered
    `CHK("pending_reads", 0, exp_q.size());
    print_verdict();
  end
endmodule // bit_rotate_flag_unit_tb
